// ===== src/cidb_core.sv
`timescale 1ns/1ps
// Contract
// - decrement-and-skip subtracts one from file register 0..127, flags untouched
// - direction 0 writes result to working register, 1 back to file register
// - decrement-and-skip zero result discards next instruction as a nop, two cycles
// - increment-and-skip adds one, zero result skips next instruction, flags untouched
// - branch loads 11-bit operand into program counter bits 10..0
// - branch copies latch bits 4..3 into program counter bits 12..11
// - branch takes two instruction cycles and leaves flags untouched
// - or-literal ors working register with 8-bit literal, result to it, zero flag updated
// - plain increment adds one, routes by direction, updates zero flag, never skips
module cidb_core #(
  parameter int FILE_DEPTH = 128
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SECOND} cidb_state_t;

  cidb_state_t               state_q;
  cidb_pkg::cidb_instr_t     instr_q;
  logic [7:0]                wreg_q;
  logic                      zero_q;
  logic                      skip_q;
  logic [cidb_pkg::PC_W-1:0] pc_q;
  logic [cidb_pkg::LATCH_W-1:0] latch_q;
  logic [6:0]                faddr_q;
  logic [7:0]                fmem [FILE_DEPTH];
  logic [31:0]               rdata_d;
  logic                      mapped;
  logic                      wr_en;
  logic                      exec;
  logic [6:0]                fa;
  logic [7:0]                fval;
  logic [7:0]                res;
  logic                      res_zero;
  logic                      is_arith;
  logic                      two_cycle;

  // writes stall while an instruction runs so software and core never race
  assign pready  = (state_q == ST_IDLE) || !pwrite;
  assign wr_en   = psel && penable && pwrite && pready && mapped;
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    mapped = 1'b1;
    case (paddr)
      cidb_pkg::OFS_INSTR, cidb_pkg::OFS_WREG, cidb_pkg::OFS_STATUS, cidb_pkg::OFS_PC,
      cidb_pkg::OFS_LATCH, cidb_pkg::OFS_FADDR, cidb_pkg::OFS_FDATA: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // operand decode and result; 8-bit sum wraps on its own
  assign exec     = (state_q == ST_EXEC) && !skip_q;
  assign fa       = instr_q.arg[6:0];
  assign fval     = fmem[fa];
  assign is_arith = (instr_q.op == cidb_pkg::OP_DECREMENT_SKIP_ZERO) ||
                    (instr_q.op == cidb_pkg::OP_INCREMENT_SKIP_ZERO) ||
                    (instr_q.op == cidb_pkg::OP_INCREMENT_FILE_REGISTER);

  always_comb begin
    res = fval;
    case (instr_q.op)
      cidb_pkg::OP_DECREMENT_SKIP_ZERO:         res = fval - 8'h01;
      cidb_pkg::OP_INCREMENT_SKIP_ZERO,
      cidb_pkg::OP_INCREMENT_FILE_REGISTER:     res = fval + 8'h01;
      cidb_pkg::OP_OR_LITERAL_INTO_ACCUMULATOR: res = wreg_q | instr_q.arg[7:0];
      default:                                  res = fval;
    endcase
  end
  assign res_zero = (res == 8'h00);

  // second cycle for a branch, or for a skip instruction whose result hit zero
  always_comb begin
    two_cycle = 1'b0;
    if (exec) begin
      case (instr_q.op)
        cidb_pkg::OP_UNCONDITIONAL_BRANCH:  two_cycle = 1'b1;
        cidb_pkg::OP_DECREMENT_SKIP_ZERO,
        cidb_pkg::OP_INCREMENT_SKIP_ZERO:   two_cycle = res_zero;
        default:                            two_cycle = 1'b0;
      endcase
    end
  end

  // sequencer: a write to the instruction register starts one instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE:   if (wr_en && paddr == cidb_pkg::OFS_INSTR) state_q <= ST_EXEC;
        ST_EXEC:   state_q <= two_cycle ? ST_SECOND : ST_IDLE;
        ST_SECOND: state_q <= ST_IDLE;
        default:   state_q <= ST_IDLE;
      endcase
    end
  end

  // instruction register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_q <= '0;
    end else if (wr_en && paddr == cidb_pkg::OFS_INSTR) begin
      instr_q <= cidb_pkg::cidb_instr_t'(pwdata[14:0]);
    end
  end

  // pending skip: the next instruction runs as a nop and clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_q <= 1'b0;
    end else if (state_q == ST_EXEC) begin
      skip_q <= exec && (instr_q.op == cidb_pkg::OP_DECREMENT_SKIP_ZERO ||
                         instr_q.op == cidb_pkg::OP_INCREMENT_SKIP_ZERO) && res_zero;
    end
  end

  // working register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wreg_q <= cidb_pkg::RST_WREG;
    end else if (exec && instr_q.op == cidb_pkg::OP_OR_LITERAL_INTO_ACCUMULATOR) begin
      wreg_q <= res;
    end else if (exec && is_arith && !instr_q.dir) begin
      wreg_q <= res;
    end else if (wr_en && paddr == cidb_pkg::OFS_WREG) begin
      wreg_q <= pwdata[7:0];
    end
  end

  // zero flag: only the or-literal and plain increment touch it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_q <= 1'b0;
    end else if (exec && (instr_q.op == cidb_pkg::OP_OR_LITERAL_INTO_ACCUMULATOR ||
                          instr_q.op == cidb_pkg::OP_INCREMENT_FILE_REGISTER)) begin
      zero_q <= res_zero;
    end
  end

  // program counter: a branch loads it, every other executed or discarded instruction advances it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q <= cidb_pkg::RST_PC;
    end else if (exec && instr_q.op == cidb_pkg::OP_UNCONDITIONAL_BRANCH) begin
      pc_q <= {latch_q[cidb_pkg::LATCH_HI:cidb_pkg::LATCH_LO], instr_q.arg};
    end else if (state_q == ST_EXEC) begin
      pc_q <= pc_q + 13'h0001;
    end else if (wr_en && paddr == cidb_pkg::OFS_PC) begin
      pc_q <= pwdata[cidb_pkg::PC_W-1:0];
    end
  end

  // latch register and file window address, software owned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_q <= cidb_pkg::RST_LATCH;
      faddr_q <= 7'h00;
    end else begin
      if (wr_en && paddr == cidb_pkg::OFS_LATCH) latch_q <= pwdata[cidb_pkg::LATCH_W-1:0];
      if (wr_en && paddr == cidb_pkg::OFS_FADDR) faddr_q <= pwdata[6:0];
    end
  end

  // file registers: data only, no reset, so they map onto plain ram
  always_ff @(posedge pclk) begin
    if (exec && is_arith && instr_q.dir) begin
      fmem[fa] <= res;
    end else if (wr_en && paddr == cidb_pkg::OFS_FDATA) begin
      fmem[faddr_q] <= pwdata[7:0];
    end
  end

  // read mux, captured in the setup phase
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (paddr)
      cidb_pkg::OFS_INSTR:  rdata_d[14:0] = instr_q;
      cidb_pkg::OFS_WREG:   rdata_d[7:0]  = wreg_q;
      cidb_pkg::OFS_STATUS: begin
        rdata_d[cidb_pkg::STAT_ZERO_BIT] = zero_q;
        rdata_d[cidb_pkg::STAT_BUSY_BIT] = (state_q != ST_IDLE);
        rdata_d[cidb_pkg::STAT_SKIP_BIT] = skip_q;
      end
      cidb_pkg::OFS_PC:     rdata_d[cidb_pkg::PC_W-1:0]    = pc_q;
      cidb_pkg::OFS_LATCH:  rdata_d[cidb_pkg::LATCH_W-1:0] = latch_q;
      cidb_pkg::OFS_FADDR:  rdata_d[6:0]  = faddr_q;
      cidb_pkg::OFS_FDATA:  rdata_d[7:0]  = fmem[faddr_q];
      default:              rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= rdata_d;
    end
  end

  a_dec_wreg: assert property (@(posedge pclk) disable iff (!presetn)
    exec && instr_q.op == cidb_pkg::OP_DECREMENT_SKIP_ZERO && !instr_q.dir |=> wreg_q == $past(fval) - 8'h01)
    else $error("decrement result wrong in working register");
  a_dest_file: assert property (@(posedge pclk) disable iff (!presetn)
    exec && is_arith && instr_q.dir |=> wreg_q == $past(wreg_q))
    else $error("working register changed with direction one");
  a_dec_skip: assert property (@(posedge pclk) disable iff (!presetn)
    exec && instr_q.op == cidb_pkg::OP_DECREMENT_SKIP_ZERO && fval == 8'h01 |=> state_q == ST_SECOND ##1 skip_q)
    else $error("decrement to zero did not skip");
  a_inc_skip: assert property (@(posedge pclk) disable iff (!presetn)
    exec && instr_q.op == cidb_pkg::OP_INCREMENT_SKIP_ZERO |=> skip_q == ($past(fval) == 8'hFF) && $stable(zero_q))
    else $error("increment skip or flag wrong");
  a_branch_pc: assert property (@(posedge pclk) disable iff (!presetn)
    exec && instr_q.op == cidb_pkg::OP_UNCONDITIONAL_BRANCH |=> pc_q[10:0] == $past(instr_q.arg))
    else $error("branch low bits wrong");
  a_branch_upper: assert property (@(posedge pclk) disable iff (!presetn)
    exec && instr_q.op == cidb_pkg::OP_UNCONDITIONAL_BRANCH |=> pc_q[12:11] == $past(latch_q[4:3]))
    else $error("branch upper bits wrong");
  a_branch_cycles: assert property (@(posedge pclk) disable iff (!presetn)
    exec && instr_q.op == cidb_pkg::OP_UNCONDITIONAL_BRANCH |=> state_q == ST_SECOND && $stable(zero_q) ##1 state_q == ST_IDLE)
    else $error("branch not two cycles");
  a_or_zero: assert property (@(posedge pclk) disable iff (!presetn)
    exec && instr_q.op == cidb_pkg::OP_OR_LITERAL_INTO_ACCUMULATOR |=>
      wreg_q == ($past(wreg_q) | $past(instr_q.arg[7:0])) && zero_q == (wreg_q == 8'h00))
    else $error("or literal result or zero flag wrong");
  a_increment_file_register_noskip: assert property (@(posedge pclk) disable iff (!presetn)
    exec && instr_q.op == cidb_pkg::OP_INCREMENT_FILE_REGISTER |=> state_q == ST_IDLE && !skip_q)
    else $error("plain increment skipped");
  a_zero_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    exec && instr_q.op == cidb_pkg::OP_INCREMENT_FILE_REGISTER && fval == 8'hFF |=> zero_q)
    else $error("increment wrap did not set zero");
endmodule

// ===== src/cidb_pkg.sv
package cidb_pkg;
  // register byte offsets on the apb slave
  localparam logic [7:0] OFS_INSTR  = 8'h00;
  localparam logic [7:0] OFS_WREG   = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_PC     = 8'h0C;
  localparam logic [7:0] OFS_LATCH  = 8'h10;
  localparam logic [7:0] OFS_FADDR  = 8'h14;
  localparam logic [7:0] OFS_FDATA  = 8'h18;

  // status register bit positions
  localparam int STAT_ZERO_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_SKIP_BIT = 2;

  // branch target split and latch bits copied into the program counter
  localparam int PC_W      = 13;
  localparam int TARGET_W  = 11;
  localparam int LATCH_W   = 5;
  localparam int LATCH_LO  = 3;
  localparam int LATCH_HI  = 4;

  // reset values
  localparam logic [7:0]      RST_WREG  = 8'h00;
  localparam logic [PC_W-1:0] RST_PC    = 13'h0000;
  localparam logic [LATCH_W-1:0] RST_LATCH = 5'h00;

  // instruction codes written into the instruction register
  typedef enum logic [2:0] {
    OP_NOP                          = 3'h0,
    OP_DECREMENT_SKIP_ZERO          = 3'h1,
    OP_INCREMENT_SKIP_ZERO          = 3'h2,
    OP_UNCONDITIONAL_BRANCH         = 3'h3,
    OP_OR_LITERAL_INTO_ACCUMULATOR  = 3'h4,
    OP_INCREMENT_FILE_REGISTER      = 3'h5
  } cidb_op_t;

  // instruction word: op [14:12], direction [11], operand [10:0]
  typedef struct packed {
    cidb_op_t             op;
    logic                 dir;
    logic [TARGET_W-1:0]  arg;
  } cidb_instr_t;
endpackage

// ===== verif/test_cidb_core.sv
`timescale 1ns/1ps
module test_cidb_core;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        last_err;
  logic [31:0] rd;
  int          fails;
  int          checked;

  cidb_core dut (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  // bench clock, 10 ns period
  always #5 pclk = ~pclk;

  task automatic summarize();
    if (fails == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; a stuck pready is left to the watchdog, a long stall counts as a mismatch
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    check("pready wait", 32'h0000_0000, {31'h0, n > 3});
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    check(what, exp, rd);
  endtask

  task automatic setf(input logic [6:0] a, input logic [7:0] v);
    xfer(1'b1, cidb_pkg::OFS_FADDR, {25'h0, a});
    xfer(1'b1, cidb_pkg::OFS_FDATA, {24'h0, v});
  endtask

  // issue one instruction, then read busy at once: high only for two-cycle work
  task automatic run(input cidb_pkg::cidb_op_t op, input logic dir, input logic [10:0] arg, input logic two);
    cidb_pkg::cidb_instr_t ins;
    ins.op  = op;
    ins.dir = dir;
    ins.arg = arg;
    xfer(1'b1, cidb_pkg::OFS_INSTR, {17'h0, ins});
    xfer(1'b0, cidb_pkg::OFS_STATUS, 32'h0000_0000);
    check("busy", {31'h0, two}, {31'h0, rd[cidb_pkg::STAT_BUSY_BIT]});
  endtask

  // watchdog, far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (5000) @(posedge pclk);
    fails++;
    summarize();
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rchk("w", cidb_pkg::OFS_WREG, 32'h0000_0000);
    rchk("status", cidb_pkg::OFS_STATUS, 32'h0000_0000);
    rchk("pc", cidb_pkg::OFS_PC, 32'h0000_0000);
    rchk("latch", cidb_pkg::OFS_LATCH, 32'h0000_0000);
    check("slverr", 32'h0000_0000, {31'h0, last_err});
    // unmapped place: refused and reads zero
    xfer(1'b1, 8'h40, 32'hFFFF_FFFF);
    check("slverr", 32'h0000_0001, {31'h0, last_err});
    rchk("unmapped", 8'h40, 32'h0000_0000);
    check("slverr", 32'h0000_0001, {31'h0, last_err});
    xfer(1'b1, cidb_pkg::OFS_WREG, 32'h0000_0055);
    // decrement without skip, result back to file
    setf(7'h05, 8'h02);
    run(cidb_pkg::OP_DECREMENT_SKIP_ZERO, 1'b1, 11'h005, 1'b0);
    rchk("file", cidb_pkg::OFS_FDATA, 32'h0000_0001);
    rchk("w", cidb_pkg::OFS_WREG, 32'h0000_0055);
    rchk("status", cidb_pkg::OFS_STATUS, 32'h0000_0000);
    // zero result into w: skip pending, zero flag untouched
    run(cidb_pkg::OP_DECREMENT_SKIP_ZERO, 1'b0, 11'h005, 1'b1);
    rchk("w", cidb_pkg::OFS_WREG, 32'h0000_0000);
    rchk("file", cidb_pkg::OFS_FDATA, 32'h0000_0001);
    rchk("status", cidb_pkg::OFS_STATUS, 32'h0000_0004);
    run(cidb_pkg::OP_OR_LITERAL_INTO_ACCUMULATOR, 1'b0, 11'h00F, 1'b0);
    rchk("w", cidb_pkg::OFS_WREG, 32'h0000_0000);
    rchk("status", cidb_pkg::OFS_STATUS, 32'h0000_0000);
    rchk("pc", cidb_pkg::OFS_PC, 32'h0000_0003);
    // or-literal sets then clears zero
    run(cidb_pkg::OP_OR_LITERAL_INTO_ACCUMULATOR, 1'b1, 11'h000, 1'b0);
    rchk("status", cidb_pkg::OFS_STATUS, 32'h0000_0001);
    run(cidb_pkg::OP_OR_LITERAL_INTO_ACCUMULATOR, 1'b0, 11'h080, 1'b0);
    rchk("w", cidb_pkg::OFS_WREG, 32'h0000_0080);
    rchk("status", cidb_pkg::OFS_STATUS, 32'h0000_0000);
    // plain increment wraps into w, sets zero, never skips
    setf(7'h03, 8'hFF);
    run(cidb_pkg::OP_INCREMENT_FILE_REGISTER, 1'b0, 11'h003, 1'b0);
    rchk("w", cidb_pkg::OFS_WREG, 32'h0000_0000);
    rchk("file", cidb_pkg::OFS_FDATA, 32'h0000_00FF);
    rchk("status", cidb_pkg::OFS_STATUS, 32'h0000_0001);
    // increment-skip at the top file address, then a discarded increment
    setf(7'h7F, 8'hFF);
    run(cidb_pkg::OP_INCREMENT_SKIP_ZERO, 1'b1, 11'h07F, 1'b1);
    rchk("status", cidb_pkg::OFS_STATUS, 32'h0000_0005);
    run(cidb_pkg::OP_INCREMENT_FILE_REGISTER, 1'b1, 11'h07F, 1'b0);
    rchk("file", cidb_pkg::OFS_FDATA, 32'h0000_0000);
    run(cidb_pkg::OP_INCREMENT_FILE_REGISTER, 1'b1, 11'h07F, 1'b0);
    rchk("file", cidb_pkg::OFS_FDATA, 32'h0000_0001);
    rchk("status", cidb_pkg::OFS_STATUS, 32'h0000_0000);
    rchk("pc", cidb_pkg::OFS_PC, 32'h0000_0009);
    // branch: only latch bits 4..3 reach the top of pc
    xfer(1'b1, cidb_pkg::OFS_LATCH, 32'h0000_0018);
    run(cidb_pkg::OP_UNCONDITIONAL_BRANCH, 1'b0, 11'h7FF, 1'b1);
    rchk("pc", cidb_pkg::OFS_PC, 32'h0000_1FFF);
    xfer(1'b1, cidb_pkg::OFS_LATCH, 32'h0000_000F);
    run(cidb_pkg::OP_UNCONDITIONAL_BRANCH, 1'b1, 11'h123, 1'b1);
    rchk("pc", cidb_pkg::OFS_PC, 32'h0000_0923);
    rchk("status", cidb_pkg::OFS_STATUS, 32'h0000_0000);
    // decrement of zero wraps to all ones, no skip, flags untouched
    setf(7'h10, 8'h00);
    run(cidb_pkg::OP_DECREMENT_SKIP_ZERO, 1'b1, 11'h010, 1'b0);
    rchk("file", cidb_pkg::OFS_FDATA, 32'h0000_00FF);
    rchk("status", cidb_pkg::OFS_STATUS, 32'h0000_0000);
    summarize();
  end
endmodule
